// ===== rtl/wwdt_consts.svh
`ifndef WWDT_CONSTS_SVH
`define WWDT_CONSTS_SVH
// Byte offsets of the register map.
`define WWDT_OFS_CTRL 4'h0
`define WWDT_OFS_MODE 4'h4
`define WWDT_OFS_STAT 4'h8
// Mode register field positions.
`define WWDT_LOAD_LSB 0
`define WWDT_FIEN_BIT 12
`define WWDT_RSTEN_BIT 13
`define WWDT_PROC_BIT 14
`define WWDT_DIS_BIT 15
`define WWDT_DELTA_LSB 16
`define WWDT_DBGH_BIT 28
`define WWDT_IDLEH_BIT 29
// Control register fields.
`define WWDT_RESTART_BIT 0
`define WWDT_KEY_LSB 24
`define WWDT_KEY_VALUE 8'hA5
// Mode register value after processor reset.
`define WWDT_MODE_RESET 32'h3FFF_2FFF
`define WWDT_MODE_MASK 32'h3FFF_FFFF
// Status bits.
`define WWDT_UNF_BIT 0
`define WWDT_ERR_BIT 1
// Slow clock prescaler.
`define WWDT_PRESCALE 128
`endif

// ===== rtl/wwdt_pkg.sv
package wwdt_pkg;
    typedef logic [11:0] wwdt_count_type;
    typedef logic [6:0] wwdt_presc_type;
endpackage : wwdt_pkg

// ===== rtl/wwdt_top.sv
`timescale 1ns/100ps
`include "wwdt_consts.svh"
// How it works
// - A 12-bit down counter is loaded from the mode register load field.
// - The counter steps once every 128 slow clock ticks.
// - After reset the load value is 0xFFF and fault reset is enabled.
// - The mode register takes one write; only processor reset reopens it.
// - Writing the mode register reloads the counter and restarts counting.
// - A keyed restart clears the prescaler and, unless above delta, reloads the counter.
// - Control writes with a wrong key are ignored.
// - Underflow sets its flag and raises fault when fault reset is enabled.
// - Restart above delta is an error, even when disabled; flag, and fault when fault reset is enabled.
// - Delta at or above load value makes a restart legal while the counter is at or below the load value; underflow wraps it to 0xFFF.
// - Interrupt follows either flag only when fault interrupt is enabled.
// - Fault with reset enabled requests a reset that clears both flags.
// - Status read or any reset clears flags, interrupt and fault.
// - Counter halts in debug or idle when the matching halt bit is set.
// - Processor reset restores initial registers and counter.
// - Fault resets processor only when select is 1, else all resets.
// - The disable bit stops the timer; clear keeps it enabled.
module wwdt_top
    import wwdt_pkg::*;
(
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic [3:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    input wire logic slck_i,
    input wire logic debug_state_i,
    input wire logic idle_state_i,
    output logic wdt_fault_o,
    output logic proc_reset_only_o,
    output logic irq_o
);
    logic slck_m_q, slck_s_q, slck_p_q;
    logic dbg_m_q, dbg_s_q, idle_m_q, idle_s_q;
    logic [31:0] mode_q;
    logic mode_locked_q;
    wwdt_count_type count_q;
    wwdt_presc_type presc_q;
    logic unf_q, err_q;
    logic ack_q;

    // The slow clock comes from another domain; the edge detector compares the second and third flops.
    always_ff @(posedge clk_i) begin
        slck_m_q <= slck_i;
        slck_s_q <= slck_m_q;
        slck_p_q <= slck_s_q;
    end

    // Halt requests are levels, so a halt that takes effect two cycles late costs nothing.
    always_ff @(posedge clk_i) begin
        dbg_m_q <= debug_state_i;
        dbg_s_q <= dbg_m_q;
        idle_m_q <= idle_state_i;
        idle_s_q <= idle_m_q;
    end

    wire slck_rise = slck_s_q && !slck_p_q;
    wire wwdt_count_type load_val = mode_q[`WWDT_LOAD_LSB +: 12];
    wire wwdt_count_type delta_val = mode_q[`WWDT_DELTA_LSB +: 12];
    wire dis = mode_q[`WWDT_DIS_BIT];
    wire halted = dis || (dbg_s_q && mode_q[`WWDT_DBGH_BIT])
        || (idle_s_q && mode_q[`WWDT_IDLEH_BIT]);

    // One-cycle answer: waitrequest is high on the first cycle of a request.
    wire req = (avs_read_i || avs_write_i) && !ack_q;
    wire acc = (avs_read_i || avs_write_i) && ack_q;
    wire wr_mode = acc && avs_write_i && avs_address_i == `WWDT_OFS_MODE;
    wire wr_ctrl = acc && avs_write_i && avs_address_i == `WWDT_OFS_CTRL;
    // Status clears on the edge that captures the read data, so an event that lands
    // between capture and clear cannot be lost; a flag set in that same cycle survives.
    wire rd_stat = req && avs_read_i && avs_address_i == `WWDT_OFS_STAT;
    wire key_ok = avs_writedata_i[`WWDT_KEY_LSB +: 8] == `WWDT_KEY_VALUE
        && avs_byteenable_i[3];
    wire restart = wr_ctrl && key_ok && avs_writedata_i[`WWDT_RESTART_BIT];
    wire mode_load = wr_mode && !mode_locked_q;
    wire tick = slck_rise && presc_q == wwdt_presc_type'(`WWDT_PRESCALE - 1);
    wire underflow = tick && !halted && count_q == 12'h000;
    // Delta at or above the load value is not exceeded while the counter is at or below it; underflow wraps the counter to 0xFFF.
    wire win_err = restart && count_q > delta_val;

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            ack_q <= 1'b0;
            avs_waitrequest_o <= 1'b1;
        end else begin
            ack_q <= req;
            avs_waitrequest_o <= !req;
        end
    end

    // Waitrequest is a flop of its own so that no logic sits between the register and the bus.

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            avs_readdata_o <= 32'h0000_0000;
        end else if (req && avs_read_i) begin
            unique case (avs_address_i)
                `WWDT_OFS_MODE: avs_readdata_o <= mode_q;
                `WWDT_OFS_STAT: avs_readdata_o <= {30'h0000_0000, err_q, unf_q};
                default: avs_readdata_o <= 32'h0000_0000;
            endcase
        end
    end

    // Mode register takes its first write only; byte enables merge into the reset value.
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            mode_q <= `WWDT_MODE_RESET;
            mode_locked_q <= 1'b0;
        end else if (wr_mode && !mode_locked_q) begin
            mode_locked_q <= 1'b1;
            for (int b = 0; b < 4; b++) begin
                if (avs_byteenable_i[b]) begin
                    mode_q[b*8 +: 8] <= avs_writedata_i[b*8 +: 8] & 8'(`WWDT_MODE_MASK >> (b*8));
                end
            end
        end
    end

    // Reload uses the written value on a mode write with both low byte enables set; otherwise it takes the old load field.
    wire wwdt_count_type new_load = avs_byteenable_i[1:0] == 2'b11
        ? avs_writedata_i[`WWDT_LOAD_LSB +: 12] : load_val;

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            presc_q <= 7'h00;
        end else if (restart || mode_load) begin
            presc_q <= 7'h00;
        end else if (slck_rise) begin
            presc_q <= presc_q + 7'h01;
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            count_q <= 12'hFFF;
        end else if (mode_load) begin
            count_q <= new_load;
        end else if (restart && !win_err) begin
            count_q <= load_val;
        end else if (tick && !halted) begin
            count_q <= count_q - 12'h001;
        end
    end

    // Set wins over a status-read clear in the same cycle, so no event slips between two reads.
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            unf_q <= 1'b0;
        end else begin
            unf_q <= underflow || (unf_q && !rd_stat);
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            err_q <= 1'b0;
        end else begin
            err_q <= win_err || (err_q && !rd_stat);
        end
    end

    // Fault and interrupt look at the events as well as the flags, so they rise one cycle
    // after the event rather than two; the reset controller never lags the status register.
    wire fault_src = underflow || win_err || ((unf_q || err_q) && !rd_stat);

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            wdt_fault_o <= 1'b0;
        end else begin
            wdt_fault_o <= mode_q[`WWDT_RSTEN_BIT] && fault_src;
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= mode_q[`WWDT_FIEN_BIT] && fault_src;
        end
    end

    // The select only steers which resets the controller raises; this block is reset either way.
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            proc_reset_only_o <= 1'b0;
        end else begin
            proc_reset_only_o <= mode_q[`WWDT_PROC_BIT];
        end
    end

    // The checks below compare registered outputs against the state one edge earlier,
    // which is where the logic above took its decision.
    a_irq_follows_flags: assert property (@(posedge clk_i) disable iff (srst_i)
        irq_o |-> $past(mode_q[`WWDT_FIEN_BIT]))
        else $error("Interrupt without enable.");

    a_mode_write_once: assert property (@(posedge clk_i) disable iff (srst_i)
        mode_locked_q && $past(mode_locked_q) |-> $stable(mode_q))
        else $error("Mode changed after lock.");

    a_bad_key_ignored: assert property (@(posedge clk_i) disable iff (srst_i)
        wr_ctrl && !key_ok && !tick |=> count_q == $past(count_q))
        else $error("Bad key changed counter.");

    a_restart_reload: assert property (@(posedge clk_i) disable iff (srst_i)
        restart && !win_err && !mode_load |=> count_q == $past(load_val) && presc_q == 7'h00)
        else $error("Restart did not reload.");

    a_window_error: assert property (@(posedge clk_i) disable iff (srst_i)
        restart && count_q > delta_val |=> err_q)
        else $error("Window error not flagged.");

    a_underflow_flag: assert property (@(posedge clk_i) disable iff (srst_i)
        underflow |=> unf_q ##0 (wdt_fault_o == $past(mode_q[`WWDT_RSTEN_BIT])))
        else $error("Underflow not reported.");

    a_halt_freeze: assert property (@(posedge clk_i) disable iff (srst_i)
        halted && !restart && !mode_load |=> count_q == $past(count_q))
        else $error("Counter moved while halted.");

    a_status_clear: assert property (@(posedge clk_i) disable iff (srst_i)
        rd_stat && !underflow && !win_err |=> !unf_q && !err_q ##1 !irq_o || unf_q || err_q)
        else $error("Status read did not clear.");

    a_reset_value: assert property (@(posedge clk_i)
        $past(srst_i) |-> mode_q == `WWDT_MODE_RESET && count_q == 12'hFFF)
        else $error("Bad reset state.");

    a_reset_flags: assert property (@(posedge clk_i)
        $past(srst_i) |-> !unf_q && !err_q && !irq_o && !wdt_fault_o)
        else $error("Flags or outputs survived reset.");

    a_fault_needs_rsten: assert property (@(posedge clk_i) disable iff (srst_i)
        wdt_fault_o |-> $past(mode_q[`WWDT_RSTEN_BIT]))
        else $error("Fault without reset enable.");

    a_proc_select: assert property (@(posedge clk_i) disable iff (srst_i)
        !$past(srst_i) |-> proc_reset_only_o == $past(mode_q[`WWDT_PROC_BIT]))
        else $error("Reset select does not follow mode.");

    a_err_only_restart: assert property (@(posedge clk_i) disable iff (srst_i)
        $rose(err_q) |-> $past(restart))
        else $error("Error flag without restart.");

    a_unf_only_tick: assert property (@(posedge clk_i) disable iff (srst_i)
        $rose(unf_q) |-> $past(tick))
        else $error("Underflow flag without tick.");

    a_lock_after_load: assert property (@(posedge clk_i) disable iff (srst_i)
        mode_load |=> mode_locked_q)
        else $error("Mode not locked after write.");

    a_mode_reload: assert property (@(posedge clk_i) disable iff (srst_i)
        mode_load && avs_byteenable_i[1:0] == 2'b11
        |=> count_q == $past(avs_writedata_i[`WWDT_LOAD_LSB +: 12]))
        else $error("Mode write did not reload.");

    a_presc_mode_clear: assert property (@(posedge clk_i) disable iff (srst_i)
        mode_load |=> presc_q == 7'h00)
        else $error("Prescaler not cleared on mode write.");

    a_err_no_reload: assert property (@(posedge clk_i) disable iff (srst_i)
        win_err && !tick |=> $stable(count_q))
        else $error("Erroneous restart reloaded counter.");

    a_delta_legal: assert property (@(posedge clk_i) disable iff (srst_i)
        restart && delta_val >= load_val && count_q <= load_val |-> !win_err)
        else $error("Restart inside open window flagged.");

    a_read_clears: assert property (@(posedge clk_i) disable iff (srst_i)
        rd_stat && !underflow && !win_err |=> !irq_o && !wdt_fault_o)
        else $error("Status read left fault or interrupt.");

    a_count_step: assert property (@(posedge clk_i) disable iff (srst_i)
        tick && !halted && !restart && !mode_load && count_q != 12'h000
        |=> count_q == $past(count_q) - 12'h001)
        else $error("Counter did not step by one.");

    a_disabled_hold: assert property (@(posedge clk_i) disable iff (srst_i)
        dis && !restart && !mode_load |=> $stable(count_q))
        else $error("Disabled counter moved.");


    c_underflow: cover property (@(posedge clk_i) disable iff (srst_i) underflow);
    c_win_err: cover property (@(posedge clk_i) disable iff (srst_i) win_err);
    c_restart_ok: cover property (@(posedge clk_i) disable iff (srst_i) restart && !win_err);
    c_mode_load: cover property (@(posedge clk_i) disable iff (srst_i) mode_load);
    c_halt_stall: cover property (@(posedge clk_i) disable iff (srst_i) tick && halted);
endmodule : wwdt_top

// ===== verif/wwdt_rstc_model.sv
`timescale 1ns/100ps
module wwdt_rstc_model (
    input wire logic clk_i,
    input wire logic fault_i,
    input wire logic proc_only_i,
    output logic rst_req_o
);
    logic [1:0] cnt_q = 2'h0;
    // Both reset kinds restart the watchdog, so the select only matters outside this block.
    always_ff @(posedge clk_i) begin
        if (fault_i && cnt_q == 2'h0) begin
            cnt_q <= 2'h3;
        end else if (cnt_q != 2'h0) begin
            cnt_q <= cnt_q - 2'h1;
        end
    end
    assign rst_req_o = (cnt_q != 2'h0);
endmodule : wwdt_rstc_model

// ===== verif/testbench.sv
`timescale 1ns/100ps
module testbench;
    import wwdt_pkg::*;
    logic clk = 0, rst_q = 1, rd = 0, wr = 0, slck = 0, dbg = 0;
    logic [3:0] adr = 4'h0;
    logic [31:0] wd = 32'h0, q, r, seed = 32'h21;
    logic [7:0] key;
    logic [31:0] rdo;
    logic wrq, flt, pro, irq, req;
    int n_errors = 0, checked = 0, cyc = 0, i;
    wwdt_top DUT (.clk_i(clk), .srst_i(rst_q | req), .avs_address_i(adr), .avs_read_i(rd),
        .avs_write_i(wr), .avs_writedata_i(wd), .avs_byteenable_i(4'hF), .avs_readdata_o(rdo),
        .avs_waitrequest_o(wrq), .slck_i(slck), .debug_state_i(dbg), .idle_state_i(1'b0),
        .wdt_fault_o(flt), .proc_reset_only_o(pro), .irq_o(irq));
    wwdt_rstc_model rstc (.clk_i(clk), .fault_i(flt), .proc_only_i(pro), .rst_req_o(req));
    initial forever #5 clk = ~clk;
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction : xs
    task end_sim();
        $display("checked %0d n_errors %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : end_sim
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        adr <= a;
        wd <= d;
        wr <= w;
        rd <= !w;
        do @(posedge clk); while (wrq !== 1'b0);
        q = rdo;
        wr <= 1'b0;
        rd <= 1'b0;
    endtask : bus
    always @(posedge clk) begin
        cyc++;
        slck <= cyc[2];
        if (cyc == 20000) begin
            n_errors++;
            end_sim();
        end
    end
    initial begin
        repeat (12) @(posedge clk);
        rst_q <= 1'b0;
        bus(0, 4'h4, 0); chk("mode", 32'h3FFF2FFF, q);
        bus(1, 4'h0, 32'hA5000001); bus(0, 4'h8, 0); chk("status", 0, q);
        $display("test defaults done");
        bus(1, 4'h4, 32'h00001001);
        bus(1, 4'h4, 32'h0); bus(0, 4'h4, 0); chk("mode", 32'h00001001, q);
        repeat (8) begin
            seed = xs(seed);
            key = (seed[31:24] == 8'hA5) ? 8'h5A : seed[31:24];
            bus(1, 4'h0, {key, seed[23:1], 1'b1});
        end
        bus(0, 4'h8, 0); chk("status", 0, q);
        bus(1, 4'h0, 32'hA5000001);
        repeat (3) @(posedge clk);
        chk("irq", 1, irq);
        chk("fault", 0, flt);
        bus(0, 4'h8, 0); chk("status", 2, q);
        bus(0, 4'h8, 0); chk("status", 0, q);
        chk("irq", 0, irq);
        for (i = 0; i < 4000 && irq !== 1'b1; i++) @(posedge clk);
        chk("tick", 1, i > 900);
        bus(0, 4'h8, 0); chk("status", 1, q);
        $display("test window done");
        rst_q <= 1'b1;
        repeat (2) @(posedge clk);
        rst_q <= 1'b0;
        bus(1, 4'h4, 32'h00006005);
        repeat (2) @(posedge clk);
        chk("proc", 1, pro);
        bus(1, 4'h0, 32'hA5000001);
        for (i = 0; i < 20 && req !== 1'b1; i++) @(posedge clk);
        chk("req", 1, req);
        repeat (8) @(posedge clk);
        bus(0, 4'h4, 0); chk("mode", 32'h3FFF2FFF, q);
        bus(0, 4'h8, 0); chk("status", 0, q);
        $display("test fault reset done");
        dbg <= 1'b1;
        bus(1, 4'h4, 32'h10001001);
        repeat (2500) @(posedge clk);
        chk("irq", 0, irq);
        dbg <= 1'b0;
        for (i = 0; i < 4000 && irq !== 1'b1; i++) @(posedge clk);
        chk("irq", 1, irq);
        bus(0, 4'h8, 0); chk("status", 1, q);
        $display("test debug halt done");
        end_sim();
    end
endmodule : testbench
